// *** rtl/jtag_isp_pkg.sv ***
// constants for the in-system configuration port and reset-state logic
// assumes one system clock domain; the test clock arrives as a sampled pin
package jtag_isp_pkg;

    // register byte offsets on the plain register port
    localparam logic [7:0] REG_PM_ZERO = 8'h00;
    localparam logic [7:0] REG_PM_TWO = 8'h04;
    localparam logic [7:0] REG_MEM_MAP = 8'h08;
    localparam logic [7:0] REG_GPIO_OUT = 8'h0C;
    localparam logic [7:0] REG_GPIO_DIR = 8'h10;
    localparam logic [7:0] REG_STATE = 8'h14;
    localparam logic [7:0] REG_IRQ_STAT = 8'h18;
    localparam logic [7:0] REG_IRQ_EN = 8'h1C;
    localparam logic [7:0] REG_IRQ_CLR = 8'h20;

    // field positions and reset values
    localparam int COD_BIT = 7;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] MEM_MAP_INIT = 8'h8F;
    localparam logic [2:0] IRQ_NONE = 3'h0;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FAIL = 1;
    localparam int IRQ_REFUSED = 2;

    // port c pin positions
    localparam int PIN_MODE = 0;
    localparam int PIN_TCK = 1;
    localparam int PIN_STAT = 3;
    localparam int PIN_ERR = 4;
    localparam int PIN_TDI = 5;
    localparam int PIN_TDO = 6;

    // instruction codes
    localparam logic [3:0] IR_ENABLE = 4'h1;
    localparam logic [3:0] IR_EXIT = 4'h3;
    localparam logic [3:0] IR_PROGRAM = 4'h4;
    localparam logic [3:0] IR_ERASE = 4'h5;
    localparam logic [3:0] IR_READ = 4'h6;
    localparam logic [3:0] IR_CHIP_ERASE = 4'h7;
    localparam logic [3:0] IR_CLR_ERR = 4'h8;
    localparam logic [3:0] IR_DRIVE_MODE = 4'h9;
    localparam logic [3:0] IR_CONFIG = 4'hA;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [3:0] IR_CAPTURE = 4'h1;

    // flash operation kinds
    localparam logic [1:0] OP_PROGRAM = 2'h1;
    localparam logic [1:0] OP_ERASE = 2'h2;
    localparam logic [1:0] OP_CHIP = 2'h3;

    // timing
    localparam int CLK_MHZ = 100;
    localparam int ABORT_US = 25;
    localparam int ABORT_CYC = ABORT_US * CLK_MHZ;
    localparam int FLASH_OP_CYC = 64;

    typedef enum logic [3:0] {
        TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
        TAP_SHIFT_DR = 4'h4, TAP_EXIT1_DR = 4'h5, TAP_PAUSE_DR = 4'h6, TAP_EXIT2_DR = 4'h7,
        TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SHIFT_IR = 4'hB,
        TAP_EXIT1_IR = 4'hC, TAP_PAUSE_IR = 4'hD, TAP_EXIT2_IR = 4'hE, TAP_UPD_IR = 4'hF
    } tap_t;

    typedef enum logic [0:0] {
        FL_IDLE = 1'b0,
        FL_BUSY = 1'b1
    } flash_t;

endpackage

// *** rtl/jtag_isp_port.sv ***
// in-system configuration port on port c, flash operation sequencer and reset-state logic
// assumes test clock, mode and data pins and the reset pin come from outside and are synchronised here
`timescale 1ns/1ps
`default_nettype none

module jtag_isp_port #(
    parameter int SECTORS = 12,
    parameter int MAIN_SECTORS = 8,
    parameter int OP_CYC = jtag_isp_pkg::FLASH_OP_CYC
) (
    // clock and power-on reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // external reset pin and power down
    input wire logic rst_pin_n_i,
    input wire logic pdn_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // port c pins
    input wire logic [7:0] pc_in_i,
    output logic [7:0] pc_out_o,
    output logic [7:0] pc_oe_n_o,
    // bus drive requests and data/address port enables
    input wire logic data_drive_i,
    input wire logic addr_drive_i,
    output logic data_oe_n_o,
    output logic addr_oe_n_o,
    // flash array
    input wire logic [7:0] flash_rdata_i,
    input wire logic flash_fail_i,
    output logic flash_start_o,
    output logic [1:0] flash_op_o,
    output logic [3:0] flash_sector_o,
    output logic [7:0] flash_data_o,
    // memory map and interrupt
    output logic [7:0] mem_map_o,
    output logic irq_o
);
    import jtag_isp_pkg::*;

    localparam logic [7:0] OP_LAST = 8'(OP_CYC - 1);

    // tap next state
    function automatic tap_t tap_next(input tap_t s, input logic m);
        case (s)
            TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            default: tap_next = TAP_RESET;
        endcase
    endfunction

    // pin synchronisers: stage one feeds stage two; the test clock also feeds stage two into a third for edge detection
    logic tck_s1, tck_s2, tck_s3, tms_s1, tms_s2, tdi_s1, tdi_s2, rst_s1, rst_s2;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {tck_s1, tck_s2, tck_s3, tms_s1, tms_s2, tdi_s1, tdi_s2} <= 7'h00;
            {rst_s1, rst_s2} <= 2'h0;
        end else begin
            {tck_s1, tck_s2, tck_s3} <= {pc_in_i[PIN_TCK], tck_s1, tck_s2};
            {tms_s1, tms_s2} <= {pc_in_i[PIN_MODE], tms_s1};
            {tdi_s1, tdi_s2} <= {pc_in_i[PIN_TDI], tdi_s1};
            {rst_s1, rst_s2} <= {rst_pin_n_i, rst_s1};
        end
    end

    wire tck_rise = tck_s2 & ~tck_s3;
    wire tck_fall = ~tck_s2 & tck_s3;
    wire warm = ~rst_s2;

    // state
    tap_t tap;
    flash_t fstate;
    logic [3:0] ir, ir_sh;
    logic [15:0] dr_sh;
    logic bypass_bit, tdo;
    logic jtag_en, ext_en, od_mode, exited, err_flag;
    logic cfg_prog, cfg_jtag, secure;
    logic [SECTORS-1:0] protect;
    logic [7:0] pm_zero, pm_two, mem_map, gpio_out, gpio_dir;
    logic [2:0] irq_stat, irq_en;
    logic [7:0] op_cnt;
    logic [3:0] op_sector;

    // command decode at update-dr
    wire upd_dr = tck_rise & (tap == TAP_UPD_DR);
    wire [3:0] cmd_sector = dr_sh[14:11];
    wire sector_ok = 32'(cmd_sector) < SECTORS;
    wire sector_prot = sector_ok & protect[cmd_sector];
    wire live = jtag_en & upd_dr;
    wire idle_fl = fstate == FL_IDLE;
    wire do_enable = upd_dr & (ir == IR_ENABLE);
    wire do_exit = live & (ir == IR_EXIT);
    wire do_prog = live & (ir == IR_PROGRAM) & ~secure & sector_ok & idle_fl;
    wire do_erase = live & (ir == IR_ERASE) & ~secure & sector_ok & ~sector_prot & idle_fl;
    wire do_chip = live & (ir == IR_CHIP_ERASE) & idle_fl;
    wire do_config = live & (ir == IR_CONFIG) & ~secure;
    wire do_clr_err = live & (ir == IR_CLR_ERR);
    wire do_drive = live & (ir == IR_DRIVE_MODE);
    wire want_op = live & ((ir == IR_PROGRAM) | (ir == IR_ERASE) | (ir == IR_CHIP_ERASE) | (ir == IR_CONFIG));
    wire refused = want_op & ~(do_prog | do_erase | do_chip | do_config);
    wire start_op = do_prog | do_erase | do_chip;
    wire op_done = (fstate == FL_BUSY) & (op_cnt == OP_LAST);
    wire op_fail = op_done & flash_fail_i;

    // read data captured into the shift register; secured part reads back zero
    wire read_ok = jtag_en & ~secure;
    wire [15:0] cap_word = (ir == IR_READ) ? (read_ok ? {8'h00, flash_rdata_i} : 16'h0000)
                         : {9'h000, secure, cfg_jtag, cfg_prog, err_flag, fstate, ext_en, jtag_en};

    // pins belong to jtag on a blank part or when the config bit is set
    wire jtag_pins = ~cfg_prog | cfg_jtag;
    wire shifting = (tap == TAP_SHIFT_DR) | (tap == TAP_SHIFT_IR);
    wire stat_val = idle_fl;
    wire err_val = ~err_flag;

    // port c drive: jtag pins first, gpio elsewhere
    logic [7:0] next_pc_out, next_pc_oe_n;
    always_comb begin
        next_pc_out = gpio_out;
        next_pc_oe_n = ~gpio_dir;
        if (jtag_pins) begin
            next_pc_out[PIN_MODE] = 1'b0;
            next_pc_oe_n[PIN_MODE] = 1'b1;
            next_pc_out[PIN_TCK] = 1'b0;
            next_pc_oe_n[PIN_TCK] = 1'b1;
            next_pc_out[PIN_TDI] = 1'b0;
            next_pc_oe_n[PIN_TDI] = 1'b1;
            next_pc_out[PIN_TDO] = tdo;
            next_pc_oe_n[PIN_TDO] = ~(jtag_en & shifting);
            if (ext_en) begin
                next_pc_out[PIN_STAT] = stat_val;
                next_pc_oe_n[PIN_STAT] = od_mode & stat_val;
                next_pc_out[PIN_ERR] = err_val;
                next_pc_oe_n[PIN_ERR] = od_mode & err_val;
            end
        end
    end

    // tap, instruction and data shift path; warm reset clears it, though not the power mode or configuration bits
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tap <= TAP_RESET;
            {ir, ir_sh} <= {IR_BYPASS, 4'h0};
            {dr_sh, bypass_bit, tdo} <= 18'h0_0000;
        end else if (warm) begin
            tap <= TAP_RESET;
            {ir, ir_sh} <= {IR_BYPASS, 4'h0};
            {dr_sh, bypass_bit, tdo} <= 18'h0_0000;
        end else if (tck_rise) begin
            tap <= tap_next(tap, tms_s2);
            case (tap)
                TAP_RESET: ir <= IR_BYPASS;
                TAP_CAP_IR: ir_sh <= IR_CAPTURE;
                TAP_SHIFT_IR: ir_sh <= {tdi_s2, ir_sh[3:1]};
                TAP_UPD_IR: ir <= ir_sh;
                TAP_CAP_DR: {dr_sh, bypass_bit} <= {cap_word, 1'b0};
                TAP_SHIFT_DR: {dr_sh, bypass_bit} <= {tdi_s2, dr_sh[15:1], tdi_s2};
                default: ir <= ir;
            endcase
        end else if (tck_fall) begin
            // data out changes on the falling test clock so the controller samples it settled
            tdo <= (tap == TAP_SHIFT_IR) ? ir_sh[0] : ((ir == IR_BYPASS) ? bypass_bit : dr_sh[0]);
        end
    end

    // channel enable, drive mode, error latch and configuration bits
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {jtag_en, ext_en, od_mode, exited, err_flag} <= 5'h00;
            {cfg_prog, cfg_jtag, secure} <= 3'h0;
            protect <= '0;
        end else begin
            if (warm) begin
                {jtag_en, ext_en, od_mode} <= 3'h0;
                if (exited) begin
                    err_flag <= 1'b0;
                    exited <= 1'b0;
                end
            end else begin
                if (do_enable) begin
                    jtag_en <= 1'b1;
                    ext_en <= dr_sh[15];
                end
                if (do_exit) begin
                    {jtag_en, ext_en} <= 2'h0;
                    exited <= 1'b1;
                end
                if (do_drive) od_mode <= dr_sh[15];
                // a failure in the same cycle as a clear keeps the pin low
                if (op_fail) err_flag <= 1'b1;
                else if (do_clr_err) err_flag <= 1'b0;
            end
            if (do_config) begin
                {cfg_prog, cfg_jtag, secure} <= {1'b1, dr_sh[15], dr_sh[14]};
                protect <= dr_sh[SECTORS-1:0];
            end else if (do_chip) begin
                {cfg_prog, cfg_jtag, secure} <= 3'h0;
                protect <= '0;
            end
        end
    end

    // flash sequencer; the reset pin drops any operation straight back to read mode
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fstate <= FL_IDLE;
            {op_cnt, op_sector} <= 12'h000;
            {flash_start_o, flash_op_o, flash_sector_o, flash_data_o} <= 15'h0000;
        end else if (warm) begin
            fstate <= FL_IDLE;
            {op_cnt, flash_start_o} <= 9'h000;
        end else begin
            flash_start_o <= start_op;
            if (start_op) begin
                fstate <= FL_BUSY;
                op_cnt <= 8'h00;
                op_sector <= cmd_sector;
                flash_op_o <= do_prog ? OP_PROGRAM : (do_erase ? OP_ERASE : OP_CHIP);
                flash_sector_o <= cmd_sector;
                flash_data_o <= dr_sh[7:0];
            end else if (op_done) begin
                fstate <= FL_IDLE;
            end else if (fstate == FL_BUSY) begin
                op_cnt <= op_cnt + 8'h01;
            end
        end
    end

    // register port decode; writes are held off in power down so registers stay put
    wire wr_ok = wr_i & ~pdn_i & ~warm;
    wire wr_pm0 = wr_ok & (addr_i == REG_PM_ZERO);
    wire wr_pm2 = wr_ok & (addr_i == REG_PM_TWO);
    wire wr_map = wr_ok & (addr_i == REG_MEM_MAP);
    wire wr_gout = wr_ok & (addr_i == REG_GPIO_OUT);
    wire wr_gdir = wr_ok & (addr_i == REG_GPIO_DIR);
    wire wr_ien = wr_ok & (addr_i == REG_IRQ_EN);
    wire wr_iclr = wr_ok & (addr_i == REG_IRQ_CLR);
    wire [2:0] irq_set = {refused, op_fail, op_done};
    wire [7:0] state_word = {1'b0, jtag_pins, secure, cfg_prog, err_flag, fstate, ext_en, jtag_en};
    wire [7:0] rd_word = (addr_i == REG_PM_ZERO) ? pm_zero :
                         (addr_i == REG_PM_TWO) ? pm_two :
                         (addr_i == REG_MEM_MAP) ? mem_map :
                         (addr_i == REG_GPIO_OUT) ? gpio_out :
                         (addr_i == REG_GPIO_DIR) ? gpio_dir :
                         (addr_i == REG_STATE) ? state_word :
                         (addr_i == REG_IRQ_STAT) ? {5'h00, irq_stat} :
                         (addr_i == REG_IRQ_EN) ? {5'h00, irq_en} : 8'h00;

    // power mode registers clear only at power-on
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {pm_zero, pm_two} <= {RST_ZERO, RST_ZERO};
        end else begin
            if (wr_pm0) pm_zero <= wdata_i;
            if (wr_pm2) pm_two <= wdata_i;
        end
    end

    // other registers reload on both resets (memory map to 0x0F, the rest to zero); code select bit always comes up zero
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mem_map <= MEM_MAP_INIT & ~(8'h01 << COD_BIT);
            {gpio_out, gpio_dir} <= {RST_ZERO, RST_ZERO};
            {irq_stat, irq_en} <= {IRQ_NONE, IRQ_NONE};
        end else if (warm) begin
            mem_map <= MEM_MAP_INIT & ~(8'h01 << COD_BIT);
            {gpio_out, gpio_dir} <= {RST_ZERO, RST_ZERO};
            {irq_stat, irq_en} <= {IRQ_NONE, IRQ_NONE};
        end else begin
            if (wr_map) mem_map <= wdata_i;
            if (wr_gout) gpio_out <= wdata_i;
            if (wr_gdir) gpio_dir <= wdata_i;
            if (wr_ien) irq_en <= wdata_i[2:0];
            // new events win over a clear in the same cycle
            irq_stat <= (irq_stat & ~(wr_iclr ? wdata_i[2:0] : IRQ_NONE)) | irq_set;
        end
    end

    // registered outputs; address and data ports float at every reset
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
            {pc_out_o, pc_oe_n_o} <= 16'h00FF;
            {data_oe_n_o, addr_oe_n_o, irq_o} <= 3'h6;
            mem_map_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? rd_word : 8'h00;
            pc_out_o <= next_pc_out;
            pc_oe_n_o <= warm ? 8'hFF : next_pc_oe_n;
            data_oe_n_o <= ~(data_drive_i & ~pdn_i & ~warm);
            addr_oe_n_o <= ~(addr_drive_i & ~warm);
            irq_o <= |(irq_stat & irq_en);
            mem_map_o <= mem_map;
        end
    end

    // helper: cycles busy since the reset pin fell
    logic [15:0] abort_cnt;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) abort_cnt <= 16'h0000;
        else if (warm && fstate == FL_BUSY) abort_cnt <= abort_cnt + 16'h0001;
        else abort_cnt <= 16'h0000;
    end

    abort_bound_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        32'(abort_cnt) < ABORT_CYC) else $error("flash abort too slow");
    abort_read_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        warm |=> fstate == FL_IDLE ##1 pc_out_o[PIN_STAT] || !ext_en) else $error("no read mode after reset");
    cod_clear_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        warm |=> !mem_map[COD_BIT]) else $error("code select not cleared");
    pm_keep_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        warm |=> pm_zero == $past(pm_zero) && pm_two == $past(pm_two)) else $error("power mode lost");
    io_input_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        warm |=> pc_oe_n_o == 8'hFF && data_oe_n_o && addr_oe_n_o) else $error("pins driven in reset");
    tdo_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !jtag_en && jtag_pins |=> pc_oe_n_o[PIN_TDO]) else $error("tdo driven before enable");
    tdo_drive_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        jtag_en && jtag_pins && tap == TAP_SHIFT_DR && !warm |=> !pc_oe_n_o[PIN_TDO]) else $error("tdo silent");
    ext_off_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !ext_en && jtag_pins && !gpio_dir[PIN_STAT] |=> pc_oe_n_o[PIN_STAT]) else $error("status pin driven");
    err_pin_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        err_flag && ext_en && jtag_pins && !warm |=> !pc_out_o[PIN_ERR] && !pc_oe_n_o[PIN_ERR])
        else $error("error pin not low");
    busy_pin_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        fstate == FL_BUSY && ext_en && jtag_pins |=> !pc_out_o[PIN_STAT]) else $error("status high while busy");
    secure_block_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        upd_dr && secure && ir != IR_CHIP_ERASE |=> !flash_start_o) else $error("secured op started");
    prot_block_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        upd_dr && ir == IR_ERASE && sector_prot |=> !flash_start_o) else $error("protected erase");
    chip_clear_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        do_chip |=> !secure && !cfg_prog && protect == '0) else $error("chip erase left config");
    err_hold_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        err_flag && !do_clr_err && !warm |=> err_flag) else $error("error flag dropped");
    en_hold_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !jtag_en && !do_enable |=> !jtag_en) else $error("channel enabled without command");

endmodule
`default_nettype wire

// *** verif/jtag_ctrl_model.sv ***
// behavioural jtag controller driving mode select, test clock and data in
// assumes the bench resolves pin levels and feeds the data-out level back
`timescale 1ns/1ps
`default_nettype none
module jtag_ctrl_model (
    // link pins
    output logic tms_o,
    output logic tck_o,
    output logic tdi_o,
    input wire logic tdo_i
);
    // test clock stands low between frames
    initial begin
        tms_o = 1'b1;
        tck_o = 1'b0;
        tdi_o = 1'b0;
    end
    // one 80 ns test-clock period; data out taken at the rise
    task automatic tbit(input logic m, input logic d, output logic q);
        tms_o = m;
        tdi_o = d;
        #40 tck_o = 1'b1;
        q = tdo_i;
        #40 tck_o = 1'b0;
    endtask
    // idle, select, capture, shift lsb first, update, idle
    // enable, option and drive-mode commands all leave through here
    task automatic scan(input logic ir, input logic [15:0] v, input int n, output logic [15:0] q);
        logic b;
        int i;
        q = 16'h0000;
        tbit(1'b0, 1'b0, b);
        tbit(1'b1, 1'b0, b);
        if (ir) tbit(1'b1, 1'b0, b);
        tbit(1'b0, 1'b0, b);
        tbit(1'b0, 1'b0, b);
        for (i = 0; i < n; i++) begin
            tbit(i == n - 1, v[i], b);
            q[i] = b;
        end
        tbit(1'b1, 1'b0, b);
        tbit(1'b0, 1'b0, b);
    endtask
endmodule
`default_nettype wire

// *** verif/jtag_isp_port_tb.sv ***
// self-checking bench for the configuration port and reset-state logic
// assumes the controller model drives the link and released pins are pulled up
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, w) begin checks++; if ((g) !== (w)) begin n_errors++; $display("unexpected %0t: %h vs %h", $time, g, w); end end
module jtag_isp_port_tb;
    import jtag_isp_pkg::*;
    logic clk_sys_i, nrst_i = 1'b0, rst_pin_n_i = 1'b1, pdn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic data_drive_i = 1'b1, addr_drive_i = 1'b1, flash_fail_i = 1'b0, saw_busy = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, pc_in_i, pc_out_o, pc_oe_n_o, flash_data_o, mem_map_o, d;
    logic [15:0] q;
    logic [3:0] flash_sector_o;
    logic [1:0] flash_op_o, last_op;
    logic data_oe_n_o, addr_oe_n_o, flash_start_o, irq_o, tms, tck, tdi;
    int n_errors = 0, checks = 0, n_start = 0, cyc = 0;
    // pin level: driven value, else controller or pull-up
    assign pc_in_i = (~pc_oe_n_o & pc_out_o) | (pc_oe_n_o & {2'b11, tdi, 3'b111, tck, tms});
    jtag_isp_port #(.OP_CYC(200)) DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .rst_pin_n_i(rst_pin_n_i),
        .pdn_i(pdn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .pc_in_i(pc_in_i), .pc_out_o(pc_out_o), .pc_oe_n_o(pc_oe_n_o), .data_drive_i(data_drive_i),
        .addr_drive_i(addr_drive_i), .data_oe_n_o(data_oe_n_o), .addr_oe_n_o(addr_oe_n_o),
        .flash_rdata_i(8'h5A), .flash_fail_i(flash_fail_i), .flash_start_o(flash_start_o),
        .flash_op_o(flash_op_o), .flash_sector_o(flash_sector_o), .flash_data_o(flash_data_o),
        .mem_map_o(mem_map_o), .irq_o(irq_o));
    jtag_ctrl_model jc (.tms_o(tms), .tck_o(tck), .tdi_o(tdi), .tdo_i(pc_in_i[PIN_TDO]));
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // flash start and busy monitor; the limit cuts a hang short
    always @(posedge clk_sys_i) begin
        cyc++;
        if (flash_start_o === 1'b1) begin
            n_start++;
            last_op = flash_op_o;
        end
        if (pc_out_o[PIN_STAT] === 1'b0) saw_busy = 1'b1;
        if (cyc == 30000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    // waits end 1 ns past the edge so registered outputs have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        // step off the edge so a following link frame never starts on a clock edge
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic cmd(input logic [3:0] op, input logic [15:0] v);
        jc.scan(1'b1, {12'h000, op}, 4, q);
        jc.scan(1'b0, v, 16, q);
        tick(4);
    endtask
    task automatic wait_ready;
        int i;
        for (i = 0; i < 400 && pc_out_o[PIN_STAT] !== 1'b1; i++) @(posedge clk_sys_i);
        `CHK(pc_out_o[PIN_STAT], 1'b1)
        tick(4);
    endtask
    task automatic t_reset;
        `CHK({pc_oe_n_o, data_oe_n_o, addr_oe_n_o}, 10'h3FF)
        rd(REG_MEM_MAP, d);
        `CHK(d, 8'h0F)
        rd(REG_STATE, d);
        `CHK(d, 8'h40)
        wr(REG_GPIO_DIR, 8'hFF);
        tick(2);
        `CHK(pc_oe_n_o, 8'h63)
        wr(REG_GPIO_DIR, 8'h00);
        pdn_i <= 1'b1;
        tick(2);
        `CHK(data_oe_n_o, 1'b1)
        pdn_i <= 1'b0;
        $display("t_reset done");
    endtask
    task automatic t_enable;
        cmd(IR_ENABLE, 16'h8000);
        rd(REG_STATE, d);
        `CHK(d, 8'h43)
        `CHK({pc_out_o[PIN_STAT], pc_oe_n_o[PIN_STAT]}, 2'b10)
        cmd(IR_DRIVE_MODE, 16'h8000);
        `CHK({pc_out_o[PIN_ERR], pc_oe_n_o[PIN_ERR]}, 2'b11)
        cmd(IR_READ, 16'h0000);
        `CHK(q, 16'h005A)
        $display("t_enable done");
    endtask
    task automatic t_program;
        flash_fail_i <= 1'b1;
        wr(REG_IRQ_EN, 8'h02);
        saw_busy = 1'b0;
        jc.scan(1'b1, {12'h000, IR_PROGRAM}, 4, q);
        `CHK(q[3:0], 4'h1)
        jc.scan(1'b0, 16'h10A5, 16, q);
        wait_ready();
        `CHK({last_op, flash_sector_o, flash_data_o}, {OP_PROGRAM, 12'h2A5})
        `CHK({saw_busy, pc_out_o[PIN_ERR], irq_o}, 3'b101)
        wr(REG_IRQ_CLR, 8'h02);
        tick(3);
        `CHK(irq_o, 1'b0)
        flash_fail_i <= 1'b0;
        cmd(IR_CLR_ERR, 16'h0000);
        `CHK(pc_out_o[PIN_ERR], 1'b1)
        $display("t_program done");
    endtask
    task automatic t_protect;
        int k;
        cmd(IR_CONFIG, 16'h8008);
        k = n_start;
        cmd(IR_ERASE, 16'h1800);
        rd(REG_IRQ_STAT, d);
        `CHK({n_start == k, d[IRQ_REFUSED]}, 2'b11)
        cmd(IR_CONFIG, 16'hC000);
        cmd(IR_PROGRAM, 16'h00A5);
        rd(REG_STATE, d);
        `CHK({n_start == k, d[6:5]}, 3'b111)
        cmd(IR_READ, 16'h0000);
        `CHK(q, 16'h0000)
        cmd(IR_CHIP_ERASE, 16'h0000);
        wait_ready();
        rd(REG_STATE, d);
        `CHK({n_start == k + 1, last_op, d}, {1'b1, OP_CHIP, 8'h43})
        $display("t_protect done");
    endtask
    task automatic t_warm;
        wr(REG_PM_ZERO, 8'h5A);
        wr(REG_MEM_MAP, 8'hF0);
        wr(REG_GPIO_DIR, 8'hFF);
        // failed program then exit, so the coming warm reset may clear the error
        flash_fail_i <= 1'b1;
        cmd(IR_PROGRAM, 16'h0000);
        wait_ready();
        flash_fail_i <= 1'b0;
        cmd(IR_EXIT, 16'h0000);
        cmd(IR_ENABLE, 16'h8000);
        cmd(IR_ERASE, 16'h0800);
        rd(REG_STATE, d);
        `CHK(d, 8'h4F)
        tick(10);
        rst_pin_n_i <= 1'b0;
        tick(10);
        `CHK({pc_oe_n_o, data_oe_n_o, addr_oe_n_o}, 10'h3FF)
        rst_pin_n_i <= 1'b1;
        tick(4);
        rd(REG_STATE, d);
        `CHK(d, 8'h40)
        rd(REG_PM_ZERO, d);
        `CHK({d, pc_oe_n_o}, 16'h5AFF)
        rd(REG_MEM_MAP, d);
        `CHK({d, mem_map_o}, 16'h0F0F)
        $display("t_warm done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        tick(2);
        t_reset();
        t_enable();
        t_program();
        t_protect();
        t_warm();
        tally_and_finish();
    end
endmodule
`default_nettype wire
